// file: logic/hpi_map.svh
`ifndef HPI_MAP_SVH
`define HPI_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define HPI_OFS_CTRL      4'h0
`define HPI_OFS_PINS      4'h1
`define HPI_OFS_STATUS    4'h2
`define HPI_OFS_MASK      4'h3

// ****************************************
// Interrupt-control field positions
// ****************************************
`define HPI_BIT_A20       7
`define HPI_BIT_HRST      6
`define HPI_BIT_PDWN      5
`define HPI_BIT_ABORT     4
`define HPI_BIT_EN3       3
`define HPI_BIT_EN2       2
`define HPI_BIT_EN1       1
`define HPI_BIT_ENERR     0

// ****************************************
// Status and mask field positions
// ****************************************
`define HPI_EV_CH1        0
`define HPI_EV_CH2        1
`define HPI_EV_CH3        2
`define HPI_EV_ERR        3

// ****************************************
// Reset values and widths
// ****************************************
`define HPI_ENABLE_RST    4'h0
`define HPI_EVENT_RST     4'h0
`define HPI_DATA_ZERO     8'h00
`define HPI_PIN_COUNT     10

`endif

// file: logic/hpi_pkg.sv
package hpi_pkg;

  // ****************************************
  // Synchronised pin bundle, pin-levels order on top
  // ****************************************
  typedef struct packed {
    logic lframe_n;
    logic clkrun_n;
    logic serirq;
    logic lreset_n;
    logic lpcpd_n;
    logic pme_n;
    logic smi_n;
    logic sci_n;
    logic a20;
    logic lclk;
  } hpi_pins_t;

  // ****************************************
  // Interrupt enables
  // ****************************************
  typedef struct packed {
    logic ch3;
    logic ch2;
    logic ch1;
    logic err;
  } hpi_enables_t;

endpackage : hpi_pkg

// file: logic/hpi_sync.sv
`timescale 1ns/1ns

module hpi_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // ****************************************
  // Two-stage synchroniser per bit
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta      <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta      <= async_i[g];
          sync_o[g] <= meta;
        end
      end
    end
  endgenerate

endmodule : hpi_sync

// file: logic/hpi_err_flag.sv
`timescale 1ns/1ns

module hpi_err_flag (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic set_i,
  input  wire logic hw_clr_i,
  input  wire logic rd_i,
  input  wire logic wr_zero_i,
  output logic      flag_o
);

  // ****************************************
  // Armed once software has seen the flag at one
  // ****************************************
  logic armed;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed <= 1'b0;
    end else if (set_i || !flag_o) begin
      armed <= 1'b0;
    end else if (rd_i) begin
      armed <= 1'b1;
    end
  end

  // Set beats any clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (hw_clr_i || (wr_zero_i && armed)) begin
      flag_o <= 1'b0;
    end
  end

endmodule : hpi_err_flag

// file: logic/hpi_irq_ctrl.sv
`timescale 1ns/1ns
`include "hpi_map.svh"

module hpi_irq_ctrl (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // ****************************************
  // Register port
  // ****************************************
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // ****************************************
  // Host-side pins
  // ****************************************
  input  wire logic       lpc_clk_i,
  input  wire logic       lframe_n_i,
  input  wire logic       clkrun_n_i,
  input  wire logic       serirq_i,
  input  wire logic       lreset_n_i,
  input  wire logic       lpcpd_n_i,
  input  wire logic       pme_n_i,
  input  wire logic       system_mgmt_irq_out_n_i,
  input  wire logic       system_ctrl_irq_out_n_i,
  input  wire logic       gate_a20_line_i,
  // ****************************************
  // Same-domain requests from the channels
  // ****************************************
  input  wire logic       ch1_rx_full_i,
  input  wire logic       ch2_rx_full_i,
  input  wire logic       ch3_rx_full_i,
  input  wire logic       shared_bidir_buffer_full_i,
  input  wire logic       shared_buffer_irq_select_i,
  input  wire logic       lpc_cycle_active_i,
  input  wire logic       lpc_sw_reset_i,
  input  wire logic       lpc_sw_shutdown_i,
  // ****************************************
  // Requests to the slave processor
  // ****************************************
  output logic            ch1_rx_irq_o,
  output logic            ch2_rx_irq_o,
  output logic            ch3_rx_irq_o,
  output logic            error_irq_o,
  output logic            irq_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  hpi_pkg::hpi_pins_t                pins_raw;
  hpi_pkg::hpi_pins_t                pins;
  logic [`HPI_PIN_COUNT-1:0]         pins_vec;

  assign pins_raw.lframe_n = lframe_n_i;
  assign pins_raw.clkrun_n = clkrun_n_i;
  assign pins_raw.serirq   = serirq_i;
  assign pins_raw.lreset_n = lreset_n_i;
  assign pins_raw.lpcpd_n  = lpcpd_n_i;
  assign pins_raw.pme_n    = pme_n_i;
  assign pins_raw.smi_n    = system_mgmt_irq_out_n_i;
  assign pins_raw.sci_n    = system_ctrl_irq_out_n_i;
  assign pins_raw.a20      = gate_a20_line_i;
  assign pins_raw.lclk     = lpc_clk_i;

  hpi_sync #(
    .W (`HPI_PIN_COUNT)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (pins_raw),
    .sync_o    (pins_vec)
  );

  assign pins = hpi_pkg::hpi_pins_t'(pins_vec);

  // ****************************************
  // Edge detection on synchronised pins
  // ****************************************
  logic lclk_prev;
  logic lreset_prev;
  logic lpcpd_prev;
  logic frame_smp;
  logic lclk_rise;
  logic lreset_fall;
  logic lpcpd_fall;
  logic frame_fall;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lclk_prev   <= 1'b0;
      lreset_prev <= 1'b0;
      lpcpd_prev  <= 1'b0;
    end else begin
      lclk_prev   <= pins.lclk;
      lreset_prev <= pins.lreset_n;
      lpcpd_prev  <= pins.lpcpd_n;
    end
  end

  assign lclk_rise   = pins.lclk & ~lclk_prev;
  assign lreset_fall = lreset_prev & ~pins.lreset_n;
  assign lpcpd_fall  = lpcpd_prev & ~pins.lpcpd_n;

  // Frame is looked at on link clock rises only, so glitches between edges are not seen
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_smp <= 1'b1;
    end else if (lclk_rise) begin
      frame_smp <= pins.lframe_n;
    end
  end

  logic frame_smp_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_smp_q <= 1'b1;
    end else begin
      frame_smp_q <= frame_smp;
    end
  end

  // One pulse per sampled fall of frame while a transfer runs
  assign frame_fall = frame_smp_q & ~frame_smp & lpc_cycle_active_i;

  // ****************************************
  // Register decode
  // ****************************************
  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl   = wr_i && (addr_i == `HPI_OFS_CTRL);
  assign rd_ctrl   = rd_i && (addr_i == `HPI_OFS_CTRL);
  assign wr_status = wr_i && (addr_i == `HPI_OFS_STATUS);
  assign wr_mask   = wr_i && (addr_i == `HPI_OFS_MASK);

  // ****************************************
  // Interrupt enables
  // ****************************************
  hpi_pkg::hpi_enables_t en;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en <= `HPI_ENABLE_RST;
    end else if (wr_ctrl) begin
      en.ch3 <= wdata_i[`HPI_BIT_EN3];
      en.ch2 <= wdata_i[`HPI_BIT_EN2];
      en.ch1 <= wdata_i[`HPI_BIT_EN1];
      en.err <= wdata_i[`HPI_BIT_ENERR];
    end
  end

  // ****************************************
  // Error flags
  // ****************************************
  logic hrst_flag;
  logic pdwn_flag;
  logic abort_flag;
  logic host_hw_reset;
  logic host_shutdown;

  assign host_hw_reset = ~pins.lreset_n | lpc_sw_reset_i;
  assign host_shutdown = ~pins.lpcpd_n | lpc_sw_shutdown_i;

  // ****************************************
  // Zero writes to the flag bits
  // ****************************************
  logic hrst_wr_zero;
  logic pdwn_wr_zero;
  logic abort_wr_zero;

  // Ones in the flag bits are dropped here, never stored
  assign hrst_wr_zero  = wr_ctrl && !wdata_i[`HPI_BIT_HRST];
  assign pdwn_wr_zero  = wr_ctrl && !wdata_i[`HPI_BIT_PDWN];
  assign abort_wr_zero = wr_ctrl && !wdata_i[`HPI_BIT_ABORT];

  hpi_err_flag u_hrst (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .set_i     (lreset_fall),
    .hw_clr_i  (1'b0),
    .rd_i      (rd_ctrl),
    .wr_zero_i (hrst_wr_zero),
    .flag_o    (hrst_flag)
  );

  hpi_err_flag u_pdwn (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .set_i     (lpcpd_fall),
    .hw_clr_i  (host_hw_reset),
    .rd_i      (rd_ctrl),
    .wr_zero_i (pdwn_wr_zero),
    .flag_o    (pdwn_flag)
  );

  hpi_err_flag u_abort (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .set_i     (frame_fall),
    .hw_clr_i  (host_hw_reset | host_shutdown),
    .rd_i      (rd_ctrl),
    .wr_zero_i (abort_wr_zero),
    .flag_o    (abort_flag)
  );

  // ****************************************
  // Gated requests to the slave processor
  // ****************************************
  logic next_ch1_irq;
  logic next_ch2_irq;
  logic next_ch3_irq;
  logic next_err_irq;

  assign next_ch1_irq = en.ch1 & ch1_rx_full_i;
  assign next_ch2_irq = en.ch2 & ch2_rx_full_i;
  // Shared buffer only joins when selected
  assign next_ch3_irq = en.ch3 & (ch3_rx_full_i |
    (shared_buffer_irq_select_i & shared_bidir_buffer_full_i));
  assign next_err_irq = en.err & (hrst_flag | pdwn_flag | abort_flag);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ch1_rx_irq_o <= 1'b0;
      ch2_rx_irq_o <= 1'b0;
      ch3_rx_irq_o <= 1'b0;
    end else begin
      ch1_rx_irq_o <= next_ch1_irq;
      ch2_rx_irq_o <= next_ch2_irq;
      ch3_rx_irq_o <= next_ch3_irq;
    end
  end

  // Error request kept apart so its enable path stays separate
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      error_irq_o <= 1'b0;
    end else begin
      error_irq_o <= next_err_irq;
    end
  end

  // ****************************************
  // Sticky status, mask and summary interrupt
  // ****************************************
  logic [3:0] req_now;
  logic [3:0] req_prev;
  logic [3:0] req_rise;
  logic [3:0] ev_status;
  logic [3:0] ev_mask;

  assign req_now = {error_irq_o, ch3_rx_irq_o, ch2_rx_irq_o, ch1_rx_irq_o};

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_prev <= `HPI_EVENT_RST;
    end else begin
      req_prev <= req_now;
    end
  end

  assign req_rise = req_now & ~req_prev;

  // A rise in the same cycle as a write of one keeps its bit set
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_status <= `HPI_EVENT_RST;
    end else if (wr_status) begin
      ev_status <= (ev_status & ~wdata_i[3:0]) | req_rise;
    end else begin
      ev_status <= ev_status | req_rise;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_mask <= `HPI_EVENT_RST;
    end else if (wr_mask) begin
      ev_mask <= wdata_i[3:0];
    end
  end

  assign irq_o = |(ev_status & ev_mask);

  // ****************************************
  // Read data, valid in the cycle after the strobe
  // ****************************************
  logic [7:0] ctrl_view;
  logic [7:0] pins_view;
  logic [7:0] next_rdata;

  always_comb begin
    ctrl_view                 = `HPI_DATA_ZERO;
    ctrl_view[`HPI_BIT_A20]   = pins.a20;
    ctrl_view[`HPI_BIT_HRST]  = hrst_flag;
    ctrl_view[`HPI_BIT_PDWN]  = pdwn_flag;
    ctrl_view[`HPI_BIT_ABORT] = abort_flag;
    ctrl_view[`HPI_BIT_EN3]   = en.ch3;
    ctrl_view[`HPI_BIT_EN2]   = en.ch2;
    ctrl_view[`HPI_BIT_EN1]   = en.ch1;
    ctrl_view[`HPI_BIT_ENERR] = en.err;
  end

  // Live levels regardless of interface state; writes here are ignored
  assign pins_view = {pins.lframe_n, pins.clkrun_n, pins.serirq, pins.lreset_n,
                      pins.lpcpd_n, pins.pme_n, pins.smi_n, pins.sci_n};

  always_comb begin
    case (addr_i)
      `HPI_OFS_CTRL:   next_rdata = ctrl_view;
      `HPI_OFS_PINS:   next_rdata = pins_view;
      `HPI_OFS_STATUS: next_rdata = {4'h0, ev_status};
      `HPI_OFS_MASK:   next_rdata = {4'h0, ev_mask};
      default:         next_rdata = `HPI_DATA_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `HPI_DATA_ZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `HPI_DATA_ZERO;
    end
  end

endmodule : hpi_irq_ctrl

// file: testbench/hpi_irq_ctrl_props.sv
`timescale 1ns/1ns

module hpi_irq_ctrl_props (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       ch1_rx_full_i,
  input wire logic       ch2_rx_full_i,
  input wire logic       ch3_rx_full_i,
  input wire logic       shared_bidir_buffer_full_i,
  input wire logic       shared_buffer_irq_select_i,
  input wire logic       ch1_rx_irq_o,
  input wire logic       ch2_rx_irq_o,
  input wire logic       ch3_rx_irq_o,
  input wire logic       error_irq_o,
  input wire logic       irq_o
);
  // ****
  // Shadow of enables and mask
  // ****
  logic [3:0] en;
  logic [3:0] mask;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en <= 4'h0;
    end else if (wr_i && addr_i == 4'h0) begin
      en <= wdata_i[3:0];
    end
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask <= 4'h0;
    end else if (wr_i && addr_i == 4'h3) begin
      mask <= wdata_i[3:0];
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr_ctrl;
    wr_i && addr_i == 4'h0;
  endsequence
  sequence s_rd_ctrl;
    rd_i && addr_i == 4'h0;
  endsequence
  a_ch1_gate: assert property (
    ch1_rx_irq_o == $past(en[1] && ch1_rx_full_i)) else $error("ch1 gate wrong");
  a_ch2_gate: assert property (
    ch2_rx_irq_o == $past(en[2] && ch2_rx_full_i)) else $error("ch2 gate wrong");
  a_ch3_gate: assert property (
    ch3_rx_irq_o == $past(en[3] && (ch3_rx_full_i
      || (shared_buffer_irq_select_i && shared_bidir_buffer_full_i))))
    else $error("ch3 gate wrong");
  a_err_gate: assert property (
    error_irq_o |-> $past(en[0])) else $error("error irq while disabled");
  a_rd_idle: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside slot");
  a_rd_unmapped: assert property (
    rd_i && addr_i > 4'h3 |=> rdata_o == 8'h00) else $error("unmapped read");
  a_en_readback: assert property (
    s_rd_ctrl |=> rdata_o[3:0] == $past(en)) else $error("enable readback");
  a_wr_then_rd: assert property (
    s_wr_ctrl ##1 s_rd_ctrl |=> rdata_o[3:0] == $past(wdata_i[3:0], 2))
    else $error("write not seen by read");
  a_irq_masked: assert property (
    irq_o |-> mask != 4'h0) else $error("irq with all masked");
endmodule : hpi_irq_ctrl_props

// file: testbench/hpi_host_model.sv
`timescale 1ns/1ns

module hpi_host_model (
  output hpi_pkg::hpi_pins_t pins_o
);
  // ****
  // Host pins; clock parked low outside frames
  // ****
  initial pins_o = 10'h2ea;
  task automatic lclk_run(input int n);
    repeat (n) begin
      #40 pins_o.lclk <= 1'b1;
      #40 pins_o.lclk <= 1'b0;
    end
  endtask : lclk_run
  task automatic host_reset();
    pins_o.lreset_n <= 1'b0;
    #160 pins_o.lreset_n <= 1'b1;
    #160;
  endtask : host_reset
  task automatic power_down();
    pins_o.lpcpd_n <= 1'b0;
    #160 pins_o.lpcpd_n <= 1'b1;
    #160;
  endtask : power_down
  // Frame drops mid-cycle, changed while the clock is low
  task automatic abort_cycle();
    lclk_run(3);
    pins_o.lframe_n <= 1'b0;
    lclk_run(3);
    pins_o.lframe_n <= 1'b1;
  endtask : abort_cycle
endmodule : hpi_host_model

// file: testbench/testbench.sv
`timescale 1ns/1ns

module testbench;
  logic               ref_clk_i;
  logic               rstn_i;
  logic               wr_i;
  logic               rd_i;
  logic [3:0]         addr_i;
  logic [7:0]         wdata_i;
  logic [7:0]         rdata_o;
  logic [7:0]         rd_val;
  logic [3:0]         full;
  wire  [2:0]         ch_o;
  logic               sel;
  logic               act;
  logic               sw_rst;
  logic               sw_sd;
  logic               err_o;
  logic               irq_o;
  hpi_pkg::hpi_pins_t pins;
  int                 fails;
  int                 total_checks;

  hpi_host_model host (.pins_o(pins));
  hpi_irq_ctrl dut (
    .ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .lpc_clk_i(pins.lclk), .lframe_n_i(pins.lframe_n), .clkrun_n_i(pins.clkrun_n),
    .serirq_i(pins.serirq), .lreset_n_i(pins.lreset_n), .lpcpd_n_i(pins.lpcpd_n),
    .pme_n_i(pins.pme_n), .system_mgmt_irq_out_n_i(pins.smi_n),
    .system_ctrl_irq_out_n_i(pins.sci_n), .gate_a20_line_i(pins.a20),
    .ch1_rx_full_i(full[0]), .ch2_rx_full_i(full[1]), .ch3_rx_full_i(full[2]),
    .shared_bidir_buffer_full_i(full[3]), .shared_buffer_irq_select_i(sel),
    .lpc_cycle_active_i(act), .lpc_sw_reset_i(sw_rst), .lpc_sw_shutdown_i(sw_sd),
    .ch1_rx_irq_o(ch_o[0]), .ch2_rx_irq_o(ch_o[1]), .ch3_rx_irq_o(ch_o[2]),
    .error_irq_o(err_o), .irq_o
  );

  // ****
  // Bus and compare tasks
  // ****
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
    @(posedge ref_clk_i);
  endtask : rd
  // Write strobe followed at once by a read strobe
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
    @(posedge ref_clk_i);
  endtask : wr_rd
  task automatic finish_test();
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    repeat (3) @(posedge ref_clk_i);
    rd(4'h0);
    check("ctrl", rd_val, {pins.a20, 7'h00});
    wr_rd(4'h0, 8'h7f);
    check("ctrl_rw", rd_val, {pins.a20, 7'h0f});
    wr(4'h1, 8'h00);
    rd(4'h1);
    check("pins", rd_val, pins[9:2]);
    rd(4'h9);
    check("unmapped", rd_val, 8'h00);
  endtask : t_reset
  task automatic t_gates();
    logic [3:0] f;
    for (int i = 0; i < 64; i++) begin
      f = i[5] ? 4'h4 : 4'hb;
      sel <= i[4];
      full <= f;
      wr(4'h0, {4'h0, i[3:0]});
      @(posedge ref_clk_i);
      check("gates", {4'h0, err_o, ch_o}, {5'h00, i[3] & (f[2] | i[4] & f[3]),
        i[2] & f[1], i[1] & f[0]});
    end
    full <= 4'h0;
  endtask : t_gates
  // Zero before any read must be refused; ones never clear
  task automatic flag_check(input logic [7:0] m);
    @(posedge ref_clk_i);
    wr(4'h0, 8'h01);
    rd(4'h0);
    check("flag_set", rd_val & 8'h70, m);
    check("err_high", {7'h00, err_o}, 8'h01);
    wr(4'h0, 8'h71);
    rd(4'h0);
    check("flag_w1", rd_val & 8'h70, m);
    wr(4'h0, 8'h01);
    rd(4'h0);
    check("flag_clr", rd_val & 8'h70, 8'h00);
    check("err_low", {7'h00, err_o}, 8'h00);
  endtask : flag_check
  task automatic t_errors();
    host.host_reset();
    flag_check(8'h40);
    host.power_down();
    flag_check(8'h20);
    act <= 1'b1;
    host.abort_cycle();
    act <= 1'b0;
    flag_check(8'h10);
  endtask : t_errors
  // Hardware clears, no software write involved
  task automatic t_hw_clear();
    act <= 1'b1;
    host.abort_cycle();
    act <= 1'b0;
    @(posedge ref_clk_i);
    rd(4'h0);
    check("abort_again", rd_val & 8'h70, 8'h10);
    sw_sd <= 1'b1;
    @(posedge ref_clk_i);
    sw_sd <= 1'b0;
    rd(4'h0);
    check("abort_sd", rd_val & 8'h70, 8'h00);
    host.power_down();
    @(posedge ref_clk_i);
    rd(4'h0);
    check("pdwn_again", rd_val & 8'h70, 8'h20);
    sw_rst <= 1'b1;
    @(posedge ref_clk_i);
    sw_rst <= 1'b0;
    rd(4'h0);
    check("pdwn_rst", rd_val & 8'h70, 8'h00);
  endtask : t_hw_clear
  task automatic t_irq();
    wr(4'h0, 8'h02);
    wr(4'h2, 8'h0f);
    wr(4'h3, 8'h01);
    check("irq_idle", {7'h00, irq_o}, 8'h00);
    full <= 4'h1;
    repeat (3) @(posedge ref_clk_i);
    check("irq_set", {7'h00, irq_o}, 8'h01);
    rd(4'h2);
    check("status", rd_val, 8'h01);
    wr(4'h3, 8'h00);
    check("irq_mask", {7'h00, irq_o}, 8'h00);
    wr(4'h2, 8'h01);
    wr(4'h3, 8'h01);
    check("irq_clr", {7'h00, irq_o}, 8'h00);
    rd(4'h2);
    check("status_clr", rd_val, 8'h00);
  endtask : t_irq

  // ****
  // Clock, reset, sequence, watchdog
  // ****
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    full = 4'h0;
    sel = 1'b0;
    act = 1'b0;
    sw_rst = 1'b0;
    sw_sd = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset();
    t_gates();
    t_errors();
    t_hw_clear();
    t_irq();
    finish_test();
  end
  // Whole run needs under 5 us
  initial begin
    #40000;
    fails++;
    finish_test();
  end
endmodule : testbench

bind hpi_irq_ctrl hpi_irq_ctrl_props props (.*);
